//--- pkg/iu_pkg.sv
// Shared constants and types of the interrupt unit.
package iu_pkg;
    // Page 0 data addresses of the unit.
    localparam logic [7:0] ADR_MASK_PT = 8'hF0;
    localparam logic [7:0] ADR_MASK_SIF = 8'hF1;
    localparam logic [7:0] ADR_MASK_K1 = 8'hF2;
    localparam logic [7:0] ADR_MASK_K0 = 8'hF3;
    localparam logic [7:0] ADR_MASK_CT = 8'hF4;
    localparam logic [7:0] ADR_FLAG_PT = 8'hF8;
    localparam logic [7:0] ADR_FLAG_SIF = 8'hF9;
    localparam logic [7:0] ADR_FLAG_K1 = 8'hFA;
    localparam logic [7:0] ADR_FLAG_K0 = 8'hFB;
    localparam logic [7:0] ADR_FLAG_CT = 8'hFC;
    localparam logic [7:0] ADR_CT_LOW = 8'h8D;
    localparam logic [7:0] ADR_CT_HIGH = 8'h8E;
    // Bit positions inside the serial nibble.
    localparam int SIF_RX_BIT = 0;
    localparam int SIF_TX_BIT = 1;
    localparam int SIF_ERR_BIT = 2;
    // Program counter layout: bank bit, page nibble, step byte.
    localparam int PC_W = 13;
    localparam logic [3:0] VEC_PAGE = 4'h1;
    localparam logic [3:0] VEC_STEP_HIGH = 4'h0;
    // Number of sources and entry timing.
    localparam int NSRC = 7;
    localparam logic [3:0] ENTRY_CYC = 4'hC;
    // Reset values.
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [3:0] CNT_RST = 4'h0;
    // Events raised by on-chip peripherals, one-cycle pulses or levels.
    typedef struct packed {
        logic pt_zero;
        logic sif_err;
        logic sif_rx;
        logic sif_tx;
        logic [3:0] ct_tap;
    } iu_evt_t;
    // Vector request handed to the CPU core.
    typedef struct packed {
        logic busy;
        logic save_pc;
        logic load_vec;
        logic [PC_W-1:0] vector;
    } iu_entry_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ENTRY = 2'b01
    } iu_state_t;
endpackage : iu_pkg

//--- hdl/iu_top.sv
// Interrupt unit: request flags, masks, priority vectoring and CPU entry timing.
//
// Behaviour
// - Flags set even when mask is zero
// - Vector stays in current program bank
// - Vectors from 102H, two words each, fixed order
// - Programmable timer flag read at F8H
// - Three serial flags share nibble F9H
// - Upper key group flag read at FAH
// - Lower key group flag read at FBH
// - Clock timer flags FCH, count 8DH/8EH
// - Timer clock key pin feeds key logic, timer
// - Entry saves PC, loads vector, 12 cycles
// - Vector replaces PC below bank bit, low nibble by fixed priority
// - Mask bit matches flag bit, F0H-F4H
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module iu_top
    import iu_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [7:0] reg_addr, // Page 0 data address.
    input wire logic [3:0] reg_wdata, // Write data nibble.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [3:0] reg_rdata, // Read data, cycle after the strobe.
    input wire iu_evt_t evt, // Peripheral events.
    input wire logic [7:0] ct_count, // Clock timer count.
    input wire logic [3:0] upper_key_input_group, // Key pins, asynchronous.
    input wire logic [3:0] lower_key_input_group, // Key pins, asynchronous.
    output logic timer_clock_key_pin, // Synchronised timer clock to the timer.
    input wire logic interrupts_enabled_state, // CPU interrupt flag.
    input wire logic [PC_W-1:0] pc, // Current program counter.
    input wire logic int_ack, // CPU starts interrupt entry.
    output logic irq, // Level request to the CPU.
    output iu_entry_t entry // Entry sequence towards the CPU.
);

    // Priority encoder used by the entry capture for the vector low nibble.
    function automatic logic [3:0] vec_low(input logic [NSRC-1:0] pend);
        logic [3:0] v;
        v = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = 4'((i + 1) * 2);
            end
        end
        return v;
    endfunction : vec_low

    logic pt_flag_r, k1_flag_r, k0_flag_r;
    logic [2:0] sif_flag_r;
    logic [3:0] ct_flag_r;
    logic pt_mask_r, k1_mask_r, k0_mask_r;
    logic [2:0] sif_mask_r;
    logic [3:0] ct_mask_r;
    logic [3:0] up_s1_r, up_s2_r, up_d_r, lo_s1_r, lo_s2_r, lo_d_r;
    logic [3:0] ct_tap_d_r, ct_high_r, cnt_r;
    logic [NSRC-1:0] pend;
    logic k1_evt, k0_evt, wr_ff;
    iu_state_t state_r;

    assign wr_ff = reg_wr;
    // Event edges; the key groups fire on either edge of any pin.
    assign k1_evt = |(up_s2_r ^ up_d_r);
    assign k0_evt = |(lo_s2_r ^ lo_d_r);

    // Key pins pass two flops before edge detection.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            up_s1_r <= NIB_RST;
            up_s2_r <= NIB_RST;
            up_d_r <= NIB_RST;
            lo_s1_r <= NIB_RST;
            lo_s2_r <= NIB_RST;
            lo_d_r <= NIB_RST;
            timer_clock_key_pin <= 1'b0;
        end else begin
            up_s1_r <= upper_key_input_group;
            up_s2_r <= up_s1_r;
            up_d_r <= up_s2_r;
            lo_s1_r <= lower_key_input_group;
            lo_s2_r <= lo_s1_r;
            lo_d_r <= lo_s2_r;
            timer_clock_key_pin <= lo_s2_r[2];
        end
    end

    // Clock timer taps are remembered to find their falling edges.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ct_tap_d_r <= NIB_RST;
        end else begin
            ct_tap_d_r <= evt.ct_tap;
        end
    end

    // Flags set on their event regardless of mask; write one clears, a set in the same cycle wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pt_flag_r <= 1'b0;
            sif_flag_r <= 3'h0;
            k1_flag_r <= 1'b0;
            k0_flag_r <= 1'b0;
            ct_flag_r <= NIB_RST;
        end else begin
            pt_flag_r <= (pt_flag_r & ~(wr_ff && reg_addr == ADR_FLAG_PT && reg_wdata[0]))
                | evt.pt_zero;
            sif_flag_r[SIF_RX_BIT] <= (sif_flag_r[SIF_RX_BIT]
                & ~(wr_ff && reg_addr == ADR_FLAG_SIF && reg_wdata[SIF_RX_BIT])) | evt.sif_rx;
            sif_flag_r[SIF_TX_BIT] <= (sif_flag_r[SIF_TX_BIT]
                & ~(wr_ff && reg_addr == ADR_FLAG_SIF && reg_wdata[SIF_TX_BIT])) | evt.sif_tx;
            sif_flag_r[SIF_ERR_BIT] <= (sif_flag_r[SIF_ERR_BIT]
                & ~(wr_ff && reg_addr == ADR_FLAG_SIF && reg_wdata[SIF_ERR_BIT])) | evt.sif_err;
            k1_flag_r <= (k1_flag_r & ~(wr_ff && reg_addr == ADR_FLAG_K1 && reg_wdata[0])) | k1_evt;
            k0_flag_r <= (k0_flag_r & ~(wr_ff && reg_addr == ADR_FLAG_K0 && reg_wdata[0])) | k0_evt;
            ct_flag_r <= (ct_flag_r & ~((wr_ff && reg_addr == ADR_FLAG_CT) ? reg_wdata : NIB_RST))
                | (ct_tap_d_r & ~evt.ct_tap);
        end
    end

    // Masks mirror the flag layout; software is trusted to write them only while interrupts are blocked.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pt_mask_r <= 1'b0;
            sif_mask_r <= 3'h0;
            k1_mask_r <= 1'b0;
            k0_mask_r <= 1'b0;
            ct_mask_r <= NIB_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ADR_MASK_PT: pt_mask_r <= reg_wdata[0];
                ADR_MASK_SIF: sif_mask_r <= reg_wdata[2:0];
                ADR_MASK_K1: k1_mask_r <= reg_wdata[0];
                ADR_MASK_K0: k0_mask_r <= reg_wdata[0];
                ADR_MASK_CT: ct_mask_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read port; reading the low count nibble freezes the high one so the pair is coherent.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= NIB_RST;
            ct_high_r <= NIB_RST;
        end else begin
            if (reg_rd && reg_addr == ADR_CT_LOW) begin
                ct_high_r <= ct_count[7:4];
            end
            if (reg_rd) begin
                case (reg_addr)
                    ADR_MASK_PT: reg_rdata <= {3'h0, pt_mask_r};
                    ADR_MASK_SIF: reg_rdata <= {1'b0, sif_mask_r};
                    ADR_MASK_K1: reg_rdata <= {3'h0, k1_mask_r};
                    ADR_MASK_K0: reg_rdata <= {3'h0, k0_mask_r};
                    ADR_MASK_CT: reg_rdata <= ct_mask_r;
                    ADR_FLAG_PT: reg_rdata <= {3'h0, pt_flag_r};
                    ADR_FLAG_SIF: reg_rdata <= {1'b0, sif_flag_r};
                    ADR_FLAG_K1: reg_rdata <= {3'h0, k1_flag_r};
                    ADR_FLAG_K0: reg_rdata <= {3'h0, k0_flag_r};
                    ADR_FLAG_CT: reg_rdata <= ct_flag_r;
                    ADR_CT_LOW: reg_rdata <= ct_count[3:0];
                    ADR_CT_HIGH: reg_rdata <= ct_high_r;
                    default: reg_rdata <= NIB_RST;
                endcase
            end else begin
                reg_rdata <= NIB_RST;
            end
        end
    end

    // Pending sources in priority order, bit 0 highest.
    assign pend = {|(ct_flag_r & ct_mask_r), k0_flag_r & k0_mask_r, k1_flag_r & k1_mask_r,
        sif_flag_r[SIF_TX_BIT] & sif_mask_r[SIF_TX_BIT], sif_flag_r[SIF_RX_BIT] & sif_mask_r[SIF_RX_BIT],
        sif_flag_r[SIF_ERR_BIT] & sif_mask_r[SIF_ERR_BIT], pt_flag_r & pt_mask_r};

    // Request level; held low during entry so the CPU cannot nest one mid-sequence.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            // Dropped in the cycle an entry is taken, so the first entry cycle never shows a stale request.
            irq <= (|pend) && interrupts_enabled_state && state_r == ST_IDLE && !(int_ack && irq);
        end
    end

    // Entry sequence: save cycle first, vector load in the last of twelve cycles.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_RST;
            entry <= '0;
        end else begin
            entry.save_pc <= 1'b0;
            entry.load_vec <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (int_ack && irq && (|pend)) begin
                        state_r <= ST_ENTRY;
                        cnt_r <= 4'h1;
                        entry.busy <= 1'b1;
                        entry.save_pc <= 1'b1;
                        entry.vector <= {pc[PC_W-1], VEC_PAGE, VEC_STEP_HIGH, vec_low(pend)};
                    end
                end
                ST_ENTRY: begin
                    cnt_r <= cnt_r + 4'h1;
                    entry.load_vec <= (cnt_r == ENTRY_CYC - 4'h1);
                    if (cnt_r == ENTRY_CYC) begin
                        state_r <= ST_IDLE;
                        cnt_r <= CNT_RST;
                        entry.busy <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    entry.busy <= 1'b0;
                end
            endcase
        end
    end

    // Checks on the logic above.
    flag_unmasked_a: assert property (@(posedge clk) disable iff (sys_rst)
        evt.pt_zero |=> pt_flag_r) else $error("timer flag not set");
    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
        (evt.sif_rx && reg_wr && reg_addr == ADR_FLAG_SIF && reg_wdata[SIF_RX_BIT]) |=> sif_flag_r[SIF_RX_BIT])
        else $error("receive event lost on clear");
    bank_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_IDLE && int_ack && irq && (|pend)) |=> entry.vector[PC_W-1] == $past(pc[PC_W-1])
        && entry.vector[11:4] == {VEC_PAGE, VEC_STEP_HIGH}) else $error("vector left bank");
    top_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_IDLE && int_ack && irq && pend[0]) |=> entry.vector[3:0] == 4'h2)
        else $error("timer vector wrong");
    low_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_IDLE && int_ack && irq && pend == 7'h40) |=> entry.vector[3:0] == 4'hE)
        else $error("clock timer vector wrong");
    entry_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(entry.save_pc) |-> ##11 entry.load_vec ##1 !entry.busy) else $error("entry not 12 cycles");
    req_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        irq |-> $past(interrupts_enabled_state) && $past(|pend)) else $error("request without cause");
    flag_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADR_FLAG_K1 && !k1_evt) |=> reg_rdata == {3'h0, $past(k1_flag_r)})
        else $error("upper key flag read wrong");
    key_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
        (lo_s2_r[2] != lo_d_r[2]) |=> k0_flag_r && timer_clock_key_pin == $past(lo_s2_r[2]))
        else $error("shared key pin missed");
    mask_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == ADR_MASK_CT) |=> ct_mask_r == $past(reg_wdata)) else $error("mask not stored");

    // A CPU blocked in one cycle sees no request in the next cycle.
    irq_blocked_a: assert property (@(posedge clk) disable iff (sys_rst)
        !interrupts_enabled_state |=> !irq)
        else $error("request while interrupts blocked");

    // The request stays low for the whole entry sequence.
    irq_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        entry.busy |-> !irq)
        else $error("request during entry");

    // Nothing pending means no request one cycle later.
    irq_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(|pend) |=> !irq)
        else $error("request with nothing pending");

    // An acknowledge without a request must not start an entry.
    ack_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_IDLE && int_ack && !irq) |=> !entry.save_pc)
        else $error("entry without request");

    // The save pulse belongs to a running entry.
    save_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
        entry.save_pc |-> entry.busy)
        else $error("save outside entry");

    // The save pulse lasts exactly one cycle.
    save_once_a: assert property (@(posedge clk) disable iff (sys_rst)
        entry.save_pc |=> !entry.save_pc)
        else $error("save pulse too long");

    // Loading the vector ends the sequence.
    load_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        entry.load_vec |=> !entry.busy)
        else $error("entry runs past vector load");

    // Without an acknowledge an idle unit stays idle.
    vec_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_IDLE && !int_ack) |=> !entry.busy)
        else $error("entry started without acknowledge");

    // The vector only moves when a new entry begins.
    vec_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(entry.vector) |-> entry.save_pc)
        else $error("vector changed mid-run");

    // The entry counter never runs past its end point.
    cnt_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        cnt_r <= ENTRY_CYC)
        else $error("entry counter overrun");

    // Writing one clears the timer flag when no event competes.
    pt_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == ADR_FLAG_PT && reg_wdata[0] && !evt.pt_zero) |=> !pt_flag_r)
        else $error("timer flag not cleared");

    // A flag is sticky until software writes its address.
    pt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pt_flag_r && !(reg_wr && reg_addr == ADR_FLAG_PT)) |=> pt_flag_r)
        else $error("timer flag lost");

    // An edge on the upper group raises its flag.
    k1_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        k1_evt |=> k1_flag_r)
        else $error("upper key flag missed");

    // An edge on the lower group raises its flag.
    k0_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        k0_evt |=> k0_flag_r)
        else $error("lower key flag missed");

    // A falling slow tap raises its flag.
    ct_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ct_tap_d_r[3] && !evt.ct_tap[3]) |=> ct_flag_r[3])
        else $error("clock timer flag missed");

    // Reading the low count nibble freezes the high one.
    ct_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == ADR_CT_LOW) |=> ct_high_r == $past(ct_count[7:4]))
        else $error("high count not frozen");

    // Read data fall back to zero outside the answer cycle.
    rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == NIB_RST)
        else $error("read data left standing");

    // The serial mask keeps the written bits.
    mask_sif_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == ADR_MASK_SIF) |=> sif_mask_r == $past(reg_wdata[2:0]))
        else $error("serial mask not stored");

    // The second synchroniser stage copies the first.
    sync_up_a: assert property (@(posedge clk) disable iff (sys_rst)
        up_s2_r == $past(up_s1_r))
        else $error("key synchroniser broken");

    // The timer clock follows the synchronised shared pin.
    tck_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        timer_clock_key_pin == $past(lo_s2_r[2]))
        else $error("timer clock not following pin");

    // A transmit event raises its flag.
    sif_tx_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        evt.sif_tx |=> sif_flag_r[SIF_TX_BIT])
        else $error("transmit flag missed");

    // An error event raises its flag.
    sif_err_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        evt.sif_err |=> sif_flag_r[SIF_ERR_BIT])
        else $error("error flag missed");
endmodule : iu_top

//--- tb/iu_cpu_model.sv
// Behavioural CPU core that answers a pending request with an entry acknowledge.
`timescale 1ns/1ps
module iu_cpu_model
    import iu_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic ack_en, // Bench lets the core take requests.
    input wire logic irq, // Request from the unit.
    input wire iu_entry_t entry, // Entry sequence from the unit.
    output logic int_ack // One-cycle entry acknowledge.
);
    // One pulse per request; waiting for busy to drop keeps a second ack out of a running entry.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_ack <= 1'b0;
        end else begin
            int_ack <= ack_en && irq && !int_ack && !entry.busy;
        end
    end
endmodule : iu_cpu_model

//--- tb/tb.sv
// Self-checking testbench of the interrupt unit with a behavioural CPU core.
`timescale 1ns/1ps
module tb;
    import iu_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_rdata;
    iu_evt_t evt = '0;
    logic [7:0] ct_count = 8'h00;
    logic [3:0] upper_keys = 4'h0;
    logic [3:0] lower_keys = 4'h0;
    logic tck_pin;
    logic ies = 1'b0;
    logic [PC_W-1:0] pc = {1'b1, 12'h345};
    logic int_ack;
    logic irq;
    logic ack_en = 1'b0;
    iu_entry_t entry;
    int num_errors = 0;
    int samples_checked = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    iu_top DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .ct_count(ct_count),
        .upper_key_input_group(upper_keys), .lower_key_input_group(lower_keys), .timer_clock_key_pin(tck_pin),
        .interrupts_enabled_state(ies), .pc(pc), .int_ack(int_ack), .irq(irq), .entry(entry));
    iu_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en), .irq(irq), .entry(entry), .int_ack(int_ack));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Single-cycle write; the strobe drops at the next edge.
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rdc(input logic [7:0] a, input logic [3:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(exp));
    endtask : rdc

    // One-cycle pulses in order timer, error, receive, transmit.
    task automatic pulse(input logic [3:0] p);
        @(posedge clk);
        {evt.pt_zero, evt.sif_err, evt.sif_rx, evt.sif_tx} <= p;
        @(posedge clk);
        {evt.pt_zero, evt.sif_err, evt.sif_rx, evt.sif_tx} <= 4'h0;
    endtask : pulse

    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            rdc(8'hF0 + 8'(i), 4'h0);
            rdc(8'hF8 + 8'(i), 4'h0);
        end
        rdc(8'h00, 4'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_flags();
        ies <= 1'b1;
        pulse(4'h8);
        rdc(ADR_FLAG_PT, 4'h1);
        check(16'(irq), 16'h0);
        wr(ADR_FLAG_PT, 4'h1);
        rdc(ADR_FLAG_PT, 4'h0);
        pulse(4'h4);
        rdc(ADR_FLAG_SIF, 4'h4);
        pulse(4'h2);
        rdc(ADR_FLAG_SIF, 4'h5);
        pulse(4'h1);
        rdc(ADR_FLAG_SIF, 4'h7);
        wr(ADR_FLAG_SIF, 4'h7);
        rdc(ADR_FLAG_SIF, 4'h0);
        ies <= 1'b0;
        ct_count <= 8'hA5;
        evt.ct_tap <= 4'hF;
        repeat (2) @(posedge clk);
        evt.ct_tap <= 4'h0;
        repeat (2) @(posedge clk);
        rdc(ADR_FLAG_CT, 4'hF);
        rdc(ADR_CT_LOW, 4'h5);
        rdc(ADR_CT_HIGH, 4'hA);
        wr(ADR_FLAG_CT, 4'hF);
        upper_keys <= 4'h8;
        lower_keys <= 4'h4;
        repeat (5) @(posedge clk);
        #1;
        check(16'(tck_pin), 16'h1);
        rdc(ADR_FLAG_K1, 4'h1);
        rdc(ADR_FLAG_K0, 4'h1);
        wr(ADR_FLAG_K1, 4'h1);
        wr(ADR_FLAG_K0, 4'h1);
        $display("test flags done");
    endtask : t_flags

    task automatic t_entry();
        logic [3:0] lows [7] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
        logic [7:0] cadr [7] = '{8'hF8, 8'hF9, 8'hF9, 8'hF9, 8'hFA, 8'hFB, 8'hFC};
        logic [3:0] cdat [7] = '{4'h1, 4'h4, 4'h1, 4'h2, 4'h1, 4'h1, 4'hF};
        int n;
        // Masks are changed only while interrupts are blocked.
        wr(ADR_MASK_PT, 4'h1);
        wr(ADR_MASK_SIF, 4'h7);
        wr(ADR_MASK_K1, 4'h1);
        wr(ADR_MASK_K0, 4'h1);
        wr(ADR_MASK_CT, 4'hF);
        pulse(4'hF);
        upper_keys <= 4'h0;
        lower_keys <= 4'h0;
        evt.ct_tap <= 4'h1;
        repeat (2) @(posedge clk);
        evt.ct_tap <= 4'h0;
        repeat (5) @(posedge clk);
        #1;
        check(16'(irq), 16'h0);
        @(posedge clk);
        ies <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            ack_en <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (!entry.save_pc && n < 20);
            ack_en <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (!entry.load_vec && n < 20);
            check(16'(entry.vector), 16'({1'b1, VEC_PAGE, VEC_STEP_HIGH, lows[i]}));
            check(16'(n), 16'd11);
            @(posedge clk);
            #1;
            check(16'(entry.busy), 16'h0);
            wr(cadr[i], cdat[i]);
        end
        repeat (3) @(posedge clk);
        #1;
        check(16'(irq), 16'h0);
        rdc(ADR_FLAG_PT, 4'h0);
        ies <= 1'b0;
        $display("test entry done");
    endtask : t_entry

    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_flags();
        t_entry();
        conclude();
    end

    // The tests need well under 2000 cycles; a hang is cut short far beyond that.
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule : tb
